/* include/ext_bus_pkg.sv */
// constants for the external read, wait and reset control block
package ext_bus_pkg;
  localparam int unsigned STATE_TIME_NS      = 4;
  localparam int unsigned RESET_PULL_STATES  = 16;
  localparam logic [4:0]  RESET_PULL_COUNT   = 5'(RESET_PULL_STATES);
  localparam logic [1:0]  WAIT_MAX           = 2'h3;
  localparam logic [20:0] RESET_FETCH_ADDR   = 21'h1f2080;
  localparam logic [23:0] RESET_FETCH_FULL   = 24'hff2080;
  localparam logic [20:0] EXT_ADDR_MASK      = 21'h1fffff;
  localparam logic [1:0]  PM_NORMAL          = 2'h0;
  localparam logic [1:0]  PM_IDLE            = 2'h1;
  localparam logic [1:0]  PM_POWERDOWN       = 2'h2;
  typedef enum logic [1:0] {CYC_IDLE, CYC_WAIT, CYC_READY} cyc_state_e;
endpackage

/* rtl/reset_pin_ctrl.sv */
// reset pin pull-down timer and reset request generation
`timescale 1ns/1ns
module reset_pin_ctrl
  import ext_bus_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // reset pin and internal reset source
  input  wire logic reset_pin_in,
  input  wire logic internal_reset,
  // pull-down control and reset to core
  output logic      reset_pin_pull,
  output logic      core_reset
);
  import ext_bus_pkg::*;

  logic       pin_prev;
  logic [4:0] pull_cnt;
  logic       next_pin_prev;
  logic [4:0] next_pull_cnt;
  logic       next_core_reset;
  logic       fall;
  logic       next_pull;

  always_comb begin
    fall            = pin_prev && !reset_pin_in;
    next_pin_prev   = reset_pin_in;
    next_pull_cnt   = pull_cnt;
    if ((fall || internal_reset) && pull_cnt == 5'h00) begin
      next_pull_cnt = RESET_PULL_COUNT;
    end else if (pull_cnt != 5'h00) begin
      next_pull_cnt = pull_cnt - 5'h01;
    end
    // level-sensitive: core held in reset while pin is low
    next_core_reset = !reset_pin_in || internal_reset;
    // pull flop mirrors a non-zero counter
    next_pull       = (next_pull_cnt != 5'h00);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev   <= 1'b1;
      pull_cnt   <= 5'h00;
      core_reset <= 1'b1;
      reset_pin_pull <= 1'b0;
    end else begin
      pin_prev   <= next_pin_prev;
      pull_cnt   <= next_pull_cnt;
      core_reset <= next_core_reset;
      reset_pin_pull <= next_pull;
    end
  end

  sequence s_pull_start;
    (pin_prev && !reset_pin_in && pull_cnt == 5'h00);
  endsequence

  a_pull_length: assert property (@(posedge clk) disable iff (!rst_n)
    s_pull_start |=> reset_pin_pull [*8] ##1 reset_pin_pull [*8] ##1 !reset_pin_pull)
    else $error("reset pull not exactly 16 state times");
  a_level_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !reset_pin_in |=> core_reset)
    else $error("low reset pin did not reset the core");
endmodule

/* rtl/ext_read_ctrl.sv */
// external read strobe, wait-state, ready and reset pin control
// Overview of operation
// - read strobe low only during external memory reads.
// - with ready high, cycle ends after programmed wait states.
// - ready low adds wait states beyond the programmed ones.
// - ready is ignored for internal memory accesses.
// - reset pin is a level input and an open-drain output.
// - reset pin falling edge or internal reset pulls pin low 16 state times.
// - reset in idle or powerdown resets fully and returns to normal mode.
// - first fetch after reset is ff2080, externally 1f2080.
// - clock doubler enabled only while its enable input is high.
`timescale 1ns/1ns
module ext_read_ctrl
  import ext_bus_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // access request from the core
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic        req_external,
  input  wire logic [1:0]  req_waits,
  input  wire logic [20:0] req_addr,
  // external memory side
  input  wire logic        ready,
  output logic             rd_n,
  output logic [20:0]      ext_addr,
  output logic             done,
  // reset pin, three signals, and internal reset source
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  input  wire logic        internal_reset,
  // power mode and fetch
  input  wire logic [1:0]  power_mode_in,
  output logic [1:0]       power_mode,
  output logic [23:0]      fetch_addr,
  output logic             core_reset,
  // clock doubler
  input  wire logic        clock_doubler_enable,
  output logic             doubler_on
);
  import ext_bus_pkg::*;

  cyc_state_e  state;
  cyc_state_e  next_state;
  logic [1:0]  wait_cnt;
  logic [1:0]  next_wait_cnt;
  logic        next_rd_n;
  logic        next_done;
  logic [20:0] next_ext_addr;
  logic        cyc_ext;
  logic        next_cyc_ext;
  logic        pull;
  logic        first_fetch;
  logic        next_first_fetch;
  logic [23:0] next_fetch_addr;
  logic [1:0]  next_power_mode;
  logic        next_doubler_on;

  reset_pin_ctrl u_reset (
    .clk            (clk),
    .rst_n          (rst_n),
    .reset_pin_in   (reset_pin_in),
    .internal_reset (internal_reset),
    .reset_pin_pull (pull),
    .core_reset     (core_reset)
  );

  // open drain: drives low only, enable while pulling
  always_comb begin
    reset_pin_out = 1'b0;
    reset_pin_oe  = pull;
  end

  function automatic logic is_ext_read(input logic ext, input logic wr);
    return ext && !wr;
  endfunction

  always_comb begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    next_rd_n     = 1'b1;
    next_done     = 1'b0;
    next_ext_addr = ext_addr;
    next_cyc_ext  = cyc_ext;
    case (state)
      CYC_IDLE: begin
        if (req && !core_reset) begin
          next_cyc_ext  = req_external;
          next_wait_cnt = req_waits;
          // first cycle after reset goes to the reset vector
          next_ext_addr = first_fetch ? RESET_FETCH_ADDR : (req_addr & EXT_ADDR_MASK);
          next_rd_n     = !is_ext_read(req_external, req_write);
          next_state    = (req_waits != 2'h0) ? CYC_WAIT : CYC_READY;
        end
      end
      CYC_WAIT: begin
        next_rd_n     = rd_n;
        next_wait_cnt = wait_cnt - 2'h1;
        if (wait_cnt == 2'h1) begin
          next_state = CYC_READY;
        end
      end
      CYC_READY: begin
        if (!cyc_ext || ready) begin
          next_done  = 1'b1;
          next_state = CYC_IDLE;
        end else begin
          next_rd_n  = rd_n;
        end
      end
      default: begin
        next_state = CYC_IDLE;
      end
    endcase
    if (core_reset) begin
      next_state = CYC_IDLE;
      next_rd_n  = 1'b1;
      next_done  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= CYC_IDLE;
      wait_cnt <= 2'h0;
      rd_n     <= 1'b1;
      done     <= 1'b0;
      ext_addr <= 21'h000000;
      cyc_ext  <= 1'b0;
    end else begin
      state    <= next_state;
      wait_cnt <= next_wait_cnt;
      rd_n     <= next_rd_n;
      done     <= next_done;
      ext_addr <= next_ext_addr;
      cyc_ext  <= next_cyc_ext;
    end
  end

  // fetch address and power mode after reset
  always_comb begin
    next_first_fetch = first_fetch;
    next_fetch_addr  = fetch_addr;
    next_power_mode  = power_mode_in;
    next_doubler_on  = clock_doubler_enable;
    if (core_reset) begin
      next_first_fetch = 1'b1;
      next_fetch_addr  = RESET_FETCH_FULL;
      next_power_mode  = PM_NORMAL;
    end else if (first_fetch && req && state == CYC_IDLE) begin
      next_first_fetch = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_fetch <= 1'b1;
      fetch_addr  <= RESET_FETCH_FULL;
      power_mode  <= PM_NORMAL;
      doubler_on  <= 1'b0;
    end else begin
      first_fetch <= next_first_fetch;
      fetch_addr  <= next_fetch_addr;
      power_mode  <= next_power_mode;
      doubler_on  <= next_doubler_on;
    end
  end

  a_rd_only_ext: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CYC_IDLE && req && !core_reset) |=>
      (rd_n == !(cyc_ext && !$past(req_write))))
    else $error("read strobe wrong for access kind");
  a_write_no_rd: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CYC_IDLE && req && !core_reset && req_write) |=> rd_n)
    else $error("read strobe asserted for a write");
  a_rd_held_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CYC_WAIT && !rd_n && !core_reset) |=> !rd_n)
    else $error("read strobe dropped during wait states");

  sequence s_take_two_waits;
    (state == CYC_IDLE && req && !core_reset && req_waits == 2'h2);
  endsequence

  sequence s_waits_then_ready;
    (!core_reset) [*3] ##0 (ready && !core_reset);
  endsequence

  a_waits_ready_hi: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_two_waits ##1 s_waits_then_ready |=> done)
    else $error("ready high cycle did not end after waits");
  a_wait_no_done: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CYC_WAIT) |=> !done)
    else $error("cycle ended inside programmed waits");
  a_ready_stretch: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CYC_READY && cyc_ext && !ready && !core_reset) |=> !done && state == CYC_READY)
    else $error("ready low did not stretch cycle");
  a_int_ignore_rdy: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CYC_READY && !cyc_ext && !core_reset) |=> done)
    else $error("internal access stretched by ready");
  a_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
    reset_pin_oe |-> !reset_pin_out ##1 core_reset)
    else $error("pulled reset pin did not reset the core");
  a_pull_internal: assert property (@(posedge clk) disable iff (!rst_n)
    (internal_reset && !pull) |=> reset_pin_oe [*8] ##1 reset_pin_oe [*8] ##1 !reset_pin_oe)
    else $error("internal reset pull not exactly 16 state times");
  a_wake_normal: assert property (@(posedge clk) disable iff (!rst_n)
    (core_reset && power_mode != PM_NORMAL) |=> power_mode == PM_NORMAL)
    else $error("reset did not return to normal mode");
  a_fetch_vector: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CYC_IDLE && req && !core_reset && first_fetch) |=>
      (ext_addr == RESET_FETCH_ADDR && fetch_addr == RESET_FETCH_FULL))
    else $error("first fetch address wrong");
  a_first_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CYC_IDLE && req && !core_reset) |=> !first_fetch)
    else $error("reset vector reused after first fetch");
  a_doubler_follow: assert property (@(posedge clk) disable iff (!rst_n)
    clock_doubler_enable |=> doubler_on)
    else $error("doubler not enabled");
  a_doubler_off: assert property (@(posedge clk) disable iff (!rst_n)
    !clock_doubler_enable |=> !doubler_on)
    else $error("doubler enabled while its input is low");
  a_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    done |=> !done)
    else $error("cycle end held longer than one cycle");
endmodule

/* tb/ext_partner.sv */
// external memory ready and board reset circuit model
`timescale 1ns/1ns
module ext_partner (
  // clock and memory strobe
  input  wire logic       clk,
  input  wire logic       rd_n,
  // stall length and board reset request
  input  wire logic [3:0] stall,
  input  wire logic       hold_rst,
  // answers
  output logic            ready,
  output logic            pull_low
);
  logic [3:0] cnt = 4'h0;
  // slow memory: ready low for stall cycles of each read
  always @(posedge clk) cnt <= rd_n ? 4'h0 : cnt + 4'(cnt != 4'hf);
  assign ready = (cnt >= stall);
  assign pull_low = hold_rst;
endmodule

/* tb/external_read_wait_and_reset_ctrl_tb.sv */
// self-checking bench for the external read, wait and reset control block
`timescale 1ns/1ns
module external_read_wait_and_reset_ctrl_tb;
  import ext_bus_pkg::*;
  logic        clk = 0, rst_n = 0, req = 0, req_write = 0, req_external = 0;
  logic        internal_reset = 0, clock_doubler_enable = 0, hold_rst = 0;
  logic [1:0]  req_waits = 0, power_mode_in = 0;
  logic [20:0] req_addr = 0;
  logic [3:0]  stall = 0;
  wire         ready, rd_n, done, rst_out, rst_oe, core_reset, doubler_on, pull_low;
  wire [20:0]  ext_addr;
  wire [1:0]   power_mode;
  wire [23:0]  fetch_addr;
  // open-drain reset wire with pull-up
  wire         pin = ~((rst_oe & ~rst_out) | pull_low);
  int          error_cnt = 0, n_compared = 0, seed = 16;
  bit          fresh = 1;
  always #2 clk = ~clk;
  ext_read_ctrl dut_u (.clk(clk), .rst_n(rst_n), .req(req), .req_write(req_write),
    .req_external(req_external), .req_waits(req_waits), .req_addr(req_addr),
    .ready(ready), .rd_n(rd_n), .ext_addr(ext_addr), .done(done), .reset_pin_in(pin),
    .reset_pin_out(rst_out), .reset_pin_oe(rst_oe), .internal_reset(internal_reset),
    .power_mode_in(power_mode_in), .power_mode(power_mode), .fetch_addr(fetch_addr),
    .core_reset(core_reset), .clock_doubler_enable(clock_doubler_enable),
    .doubler_on(doubler_on));
  ext_partner mem_u (.clk(clk), .rd_n(rd_n), .stall(stall), .hold_rst(hold_rst),
    .ready(ready), .pull_low(pull_low));
  task chk(string what, logic [23:0] exp, logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task access(bit ext, bit wr, logic [1:0] w, logic [3:0] st);
    int n, c;
    bit lo;
    // model: ready sampled only after the waits, low for st strobe cycles
    n = 1 + w;
    if (ext && !wr && st > w)
      n = 1 + st;
    @(posedge clk);
    #1 {req, req_write, req_external, req_waits, stall} = {1'b1, wr, ext, w, st};
    req_addr = 21'($random(seed));
    clock_doubler_enable = 1'($random(seed));
    @(posedge clk);
    #1 req = 0;
    c = 0;
    lo = 0;
    chk("doubler_on", clock_doubler_enable, doubler_on);
    chk("ext_addr", fresh ? RESET_FETCH_ADDR : req_addr, ext_addr);
    fresh = 0;
    while (done !== 1'b1 && c < 40) begin
      lo |= (rd_n === 1'b0);
      @(posedge clk);
      #1 c++;
    end
    chk("cycles", n, c);
    chk("rd_n low seen", ext && !wr, lo);
  endtask
  task pin_pulse(bit from_core);
    int c;
    @(posedge clk);
    #1 if (from_core) internal_reset = 1; else hold_rst = 1;
    fresh = 1;
    c = 0;
    for (int i = 0; i < 30; i++) begin
      if (i == 2) {internal_reset, hold_rst} = 2'h0;
      if (i == 5) chk("core_reset", 1'b1, core_reset);
      if (i == 5) chk("power_mode", PM_NORMAL, power_mode);
      if (i == 5) chk("reset_pin_out", 1'b0, rst_out);
      c += (rst_oe === 1'b1);
      @(posedge clk);
      #1;
    end
    chk("pull cycles", RESET_PULL_STATES, c);
    chk("fetch_addr", RESET_FETCH_FULL, fetch_addr);
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000 error_cnt++;
    stop_test;
  end
  initial begin
    bit e, w;
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    #1 chk("fetch_addr", RESET_FETCH_FULL, fetch_addr);
    for (int i = 0; i < 30; i++) begin
      e = 1'($random(seed));
      w = 1'($random(seed));
      // internal accesses run with ready held low
      access(e, w, 2'($random(seed)), !e ? 4'hf : w ? 4'h0 : 4'($random(seed) & 7));
    end
    power_mode_in = PM_IDLE;
    pin_pulse(0);
    power_mode_in = PM_POWERDOWN;
    pin_pulse(1);
    power_mode_in = PM_NORMAL;
    access(1, 0, 2'h3, 4'h6);
    stop_test;
  end
endmodule
